// ### verilog/timer_unit_pkg.sv
// constants shared by the timer unit event and activation logic
package timer_unit_pkg;

  // ==========================================================
  // geometry
  localparam int NUM_CH = 6;
  localparam int NUM_SLOT = 6;
  localparam int CNT_W = 16;
  localparam int FLAG_W = 8;
  localparam int NUM_DMA = 5;

  // ==========================================================
  // flag layout inside a status / enable register
  localparam int SLOT_A = 0;
  localparam int OVF_BIT = 6;
  localparam int UNF_BIT = 7;

  // ==========================================================
  // per-channel register offsets (address = channel * 16 + offset)
  localparam logic [3:0] OFF_STATUS = 4'h0;
  localparam logic [3:0] OFF_IRQ_EN = 4'h1;
  localparam logic [3:0] OFF_MODE = 4'h2;
  localparam logic [3:0] OFF_IOC = 4'h3;
  localparam logic [3:0] OFF_CNT = 4'h4;
  localparam logic [3:0] OFF_GRA = 4'h5;

  // ==========================================================
  // global register addresses
  localparam logic [7:0] ADDR_START = 8'h80;
  localparam logic [7:0] ADDR_OE = 8'h81;
  localparam logic [7:0] ADDR_XCAP = 8'h82;

  // ==========================================================
  // io control fields
  localparam int IOC_INIT_A = 0;
  localparam int IOC_INIT_B = 1;
  localparam int IOC_MATCH_A = 2;

  // ==========================================================
  // implemented sources per channel, channel 0 rightmost
  localparam logic [NUM_CH-1:0][FLAG_W-1:0] SRC_MASK =
    {8'h47, 8'h4f, 8'h4f, 8'hc3, 8'hc3, 8'h7f};
  // sources usable as transfer-controller activation
  localparam logic [NUM_CH-1:0][FLAG_W-1:0] DTC_MASK =
    {8'h07, 8'h4f, 8'h0f, 8'h03, 8'h03, 8'h0f};
  // channel 0 slots set by compare match only
  localparam logic [FLAG_W-1:0] CH0_CMP_ONLY = 8'h30;

  // ==========================================================
  // values after reset
  localparam logic [FLAG_W-1:0] RST_FLAGS = 8'h00;
  localparam logic [CNT_W-1:0] RST_CNT = 16'h0000;
  localparam logic [CNT_W-1:0] RST_GRA = 16'hffff;
  localparam logic [2:0] RST_IOC = 3'h0;
  localparam logic [NUM_CH-1:0] RST_START = 6'h00;
  localparam logic [NUM_CH-1:0] RST_OE = 6'h00;
  localparam logic RST_XCAP = 1'b0;

  // ==========================================================
  // operating modes
  typedef enum logic [3:0] {
    MODE_NORMAL = 4'h0,
    MODE_PWM1 = 4'h2,
    MODE_PWM2 = 4'h3,
    MODE_PHASE1 = 4'h4,
    MODE_PHASE2 = 4'h5,
    MODE_PHASE3 = 4'h6,
    MODE_PHASE4 = 4'h7
  } mode_e;

endpackage : timer_unit_pkg

// ### verilog/timer_unit_irq.sv
// timer unit counters, event flags, request outputs and output pins
// How it works
// - capture or compare sets the slot flag; request only while its enable is 1
// - capture/compare request stays until its flag is cleared to 0
// - 21 capture/compare sources: 6,2,2,4,4,3 on channels 0 to 5
// - channel 0 slots five and six set only by compare match
// - counter overflow sets overflow flag, request when overflow enable is 1
// - overflow request held until overflow flag cleared to 0
// - underflow sets underflow flag, request when enabled, held until cleared
// - underflow exists only on channels 1 and 2
// - transfer activation from capture/compare of all channels except ch 0 slots five and six, overflow only ch 4
// - 20 transfer sources: 4,2,2,4,5,3 on channels 0 to 5
// - dma activation only from register-A events of channels 0 to 4
// - dma bus request clears the register-A activation flag
// - after reset outputs low and mode is normal
// - start register bit runs or stops each channel counter
// - selecting pwm mode 1 drives positive low and negative high
// - in pwm mode 1 pin initialization leaves the b-side pin alone
// - capture-source bit adds channel 1 pin a to channel 2 register a
module timer_unit_irq #(
  parameter int CNT_W = timer_unit_pkg::CNT_W
) (
  input wire logic sys_clk_i,
  input wire logic srst_i,
  input wire logic [7:0] addr_i,
  input wire logic [15:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [15:0] rdata_o,
  input wire logic [35:0] capture_i,
  input wire logic [35:0] compare_i,
  input wire logic [2:1] count_down_i,
  input wire logic [4:0] dma_bus_req_i,
  output logic [47:0] irq_o,
  output logic [47:0] dtc_req_o,
  output logic [4:0] dma_req_o,
  output logic [5:0] out_pos_o,
  output logic [5:0] out_neg_o
);

  localparam int NCH = timer_unit_pkg::NUM_CH;
  localparam int NSL = timer_unit_pkg::NUM_SLOT;
  localparam int FW = timer_unit_pkg::FLAG_W;

  // ==========================================================
  // state
  logic [NCH-1:0][FW-1:0] flag_q;
  logic [NCH-1:0][FW-1:0] flag_d;
  logic [NCH-1:0][FW-1:0] en_q;
  logic [NCH-1:0][3:0] mode_q;
  logic [NCH-1:0][2:0] ioc_q;
  logic [NCH-1:0][CNT_W-1:0] cnt_q;
  logic [NCH-1:0][CNT_W-1:0] gra_q;
  logic [NCH-1:0] start_q;
  logic [NCH-1:0] oe_q;
  logic xcap_q;
  logic [NCH-1:0][FW-1:0] evt;
  logic [NCH-1:0] ch_sel;
  logic [NCH-1:0] down;

  // ==========================================================
  // decode helpers
  function automatic logic ch_hit(input logic [7:0] a, input int ch, input logic [3:0] off);
    ch_hit = (a[7:4] == 4'(ch)) && (a[3:0] == off);
  endfunction : ch_hit

  function automatic logic in_phase(input logic [3:0] m);
    in_phase = (m[3:2] == 2'b01);
  endfunction : in_phase

  // ==========================================================
  // event detection
  always_comb begin
    for (int c = 0; c < NCH; c++) begin
      ch_sel[c] = (c == 1 || c == 2);
      down[c] = ch_sel[c] && in_phase(mode_q[c]) && count_down_i[c == 2 ? 2 : 1];
      evt[c] = '0;
      for (int s = 0; s < NSL; s++) begin
        evt[c][s] = compare_i[c*NSL+s];
        if (!(c == 0 && timer_unit_pkg::CH0_CMP_ONLY[s])) begin
          evt[c][s] = evt[c][s] | capture_i[c*NSL+s];
        end
      end
      if (start_q[c] && (cnt_q[c] == gra_q[c])) begin
        evt[c][timer_unit_pkg::SLOT_A] = 1'b1;
      end
      if (start_q[c] && !down[c] && (cnt_q[c] == '1)) begin
        evt[c][timer_unit_pkg::OVF_BIT] = 1'b1;
      end
      if (start_q[c] && down[c] && (cnt_q[c] == '0)) begin
        evt[c][timer_unit_pkg::UNF_BIT] = 1'b1;
      end
      if (c == 2 && xcap_q && capture_i[NSL]) begin
        evt[c][timer_unit_pkg::SLOT_A] = 1'b1;
      end
      evt[c] = evt[c] & timer_unit_pkg::SRC_MASK[c];
    end
  end

  // ==========================================================
  // flags: write 0 clears, set wins over clear
  always_comb begin
    for (int c = 0; c < NCH; c++) begin
      flag_d[c] = flag_q[c];
      if (wr_i && ch_hit(addr_i, c, timer_unit_pkg::OFF_STATUS)) begin
        flag_d[c] = flag_q[c] & wdata_i[FW-1:0];
      end
      if (c < timer_unit_pkg::NUM_DMA && dma_bus_req_i[c]) begin
        flag_d[c][timer_unit_pkg::SLOT_A] = 1'b0;
      end
      flag_d[c] = flag_d[c] | evt[c];
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      flag_q <= {NCH{timer_unit_pkg::RST_FLAGS}};
    end else begin
      flag_q <= flag_d;
    end
  end

  // ==========================================================
  // control registers
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      en_q <= {NCH{timer_unit_pkg::RST_FLAGS}};
    end else begin
      for (int c = 0; c < NCH; c++) begin
        if (wr_i && ch_hit(addr_i, c, timer_unit_pkg::OFF_IRQ_EN)) begin
          en_q[c] <= wdata_i[FW-1:0] & timer_unit_pkg::SRC_MASK[c];
        end
      end
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      mode_q <= {NCH{timer_unit_pkg::MODE_NORMAL}};
    end else begin
      for (int c = 0; c < NCH; c++) begin
        if (wr_i && ch_hit(addr_i, c, timer_unit_pkg::OFF_MODE)) begin
          mode_q[c] <= wdata_i[3:0];
        end
      end
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      ioc_q <= {NCH{timer_unit_pkg::RST_IOC}};
    end else begin
      for (int c = 0; c < NCH; c++) begin
        if (wr_i && ch_hit(addr_i, c, timer_unit_pkg::OFF_IOC)) begin
          ioc_q[c] <= wdata_i[2:0];
        end
      end
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      start_q <= timer_unit_pkg::RST_START;
    end else if (wr_i && addr_i == timer_unit_pkg::ADDR_START) begin
      start_q <= wdata_i[NCH-1:0];
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      oe_q <= timer_unit_pkg::RST_OE;
    end else if (wr_i && addr_i == timer_unit_pkg::ADDR_OE) begin
      oe_q <= wdata_i[NCH-1:0];
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      xcap_q <= timer_unit_pkg::RST_XCAP;
    end else if (wr_i && addr_i == timer_unit_pkg::ADDR_XCAP) begin
      xcap_q <= wdata_i[0];
    end
  end

  // ==========================================================
  // counters and register a
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      cnt_q <= {NCH{timer_unit_pkg::RST_CNT}};
    end else begin
      for (int c = 0; c < NCH; c++) begin
        if (wr_i && ch_hit(addr_i, c, timer_unit_pkg::OFF_CNT)) begin
          cnt_q[c] <= wdata_i[CNT_W-1:0];
        end else if (start_q[c]) begin
          cnt_q[c] <= down[c] ? cnt_q[c] - 1'b1 : cnt_q[c] + 1'b1;
        end
      end
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      gra_q <= {NCH{timer_unit_pkg::RST_GRA}};
    end else begin
      for (int c = 0; c < NCH; c++) begin
        if (wr_i && ch_hit(addr_i, c, timer_unit_pkg::OFF_GRA)) begin
          gra_q[c] <= wdata_i[CNT_W-1:0];
        end else if (capture_i[c*NSL] || (c == 2 && xcap_q && capture_i[NSL])) begin
          gra_q[c] <= cnt_q[c];
        end
      end
    end
  end

  // ==========================================================
  // output pins
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      out_pos_o <= '0;
      out_neg_o <= '0;
    end else begin
      for (int c = 0; c < NCH; c++) begin
        if (wr_i && ch_hit(addr_i, c, timer_unit_pkg::OFF_MODE)
            && wdata_i[3:0] == timer_unit_pkg::MODE_PWM1) begin
          out_pos_o[c] <= 1'b0;
          out_neg_o[c] <= 1'b1;
        end else if (wr_i && ch_hit(addr_i, c, timer_unit_pkg::OFF_IOC)
            && ((c != 3 && c != 4) || oe_q[c])) begin
          out_pos_o[c] <= wdata_i[timer_unit_pkg::IOC_INIT_A];
          if (mode_q[c] != timer_unit_pkg::MODE_PWM1) begin
            out_neg_o[c] <= wdata_i[timer_unit_pkg::IOC_INIT_B];
          end
        end else if (evt[c][timer_unit_pkg::SLOT_A]) begin
          out_pos_o[c] <= ioc_q[c][timer_unit_pkg::IOC_MATCH_A];
        end
      end
    end
  end

  // ==========================================================
  // request outputs, registered flag-and-enable levels
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      irq_o <= '0;
      dtc_req_o <= '0;
      dma_req_o <= '0;
    end else begin
      for (int c = 0; c < NCH; c++) begin
        irq_o[c*FW +: FW] <= flag_q[c] & en_q[c];
        dtc_req_o[c*FW +: FW] <= flag_q[c] & en_q[c] & timer_unit_pkg::DTC_MASK[c];
        if (c < timer_unit_pkg::NUM_DMA) begin
          dma_req_o[c] <= flag_q[c][timer_unit_pkg::SLOT_A]
            & en_q[c][timer_unit_pkg::SLOT_A];
        end
      end
    end
  end

  // ==========================================================
  // read port, data one cycle after the strobe
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      rdata_o <= '0;
    end else begin
      rdata_o <= '0;
      if (rd_i) begin
        for (int c = 0; c < NCH; c++) begin
          if (ch_hit(addr_i, c, timer_unit_pkg::OFF_STATUS)) begin
            rdata_o <= {8'h00, flag_q[c]};
          end
          if (ch_hit(addr_i, c, timer_unit_pkg::OFF_IRQ_EN)) begin
            rdata_o <= {8'h00, en_q[c]};
          end
          if (ch_hit(addr_i, c, timer_unit_pkg::OFF_MODE)) begin
            rdata_o <= {12'h000, mode_q[c]};
          end
          if (ch_hit(addr_i, c, timer_unit_pkg::OFF_IOC)) begin
            rdata_o <= {13'h0000, ioc_q[c]};
          end
          if (ch_hit(addr_i, c, timer_unit_pkg::OFF_CNT)) begin
            rdata_o <= 16'(cnt_q[c]);
          end
          if (ch_hit(addr_i, c, timer_unit_pkg::OFF_GRA)) begin
            rdata_o <= 16'(gra_q[c]);
          end
        end
        if (addr_i == timer_unit_pkg::ADDR_START) begin
          rdata_o <= {10'h000, start_q};
        end
        if (addr_i == timer_unit_pkg::ADDR_OE) begin
          rdata_o <= {10'h000, oe_q};
        end
        if (addr_i == timer_unit_pkg::ADDR_XCAP) begin
          rdata_o <= {15'h0000, xcap_q};
        end
      end
    end
  end

endmodule : timer_unit_irq

// ### tb/timer_unit_irq_properties.sv
// assertions on the timer unit request and pin ports
module timer_unit_irq_properties #(
  parameter int CNT_W = 16
) (
  input wire logic sys_clk_i,
  input wire logic srst_i,
  input wire logic [7:0] addr_i,
  input wire logic [15:0] wdata_i,
  input wire logic wr_i,
  input wire logic [35:0] capture_i,
  input wire logic [35:0] compare_i,
  input wire logic [4:0] dma_bus_req_i,
  input wire logic [47:0] irq_o,
  input wire logic [47:0] dtc_req_o,
  input wire logic [4:0] dma_req_o,
  input wire logic [5:0] out_pos_o,
  input wire logic [5:0] out_neg_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========
  // properties
  default clocking @(posedge sys_clk_i);
  endclocking
  default disable iff (srst_i);
  src_mask_a: assert property ((irq_o & ~timer_unit_pkg::SRC_MASK) == '0)
    else $error("request on absent source");
  dtc_mask_a: assert property ((dtc_req_o & ~timer_unit_pkg::DTC_MASK) == '0)
    else $error("transfer request on wrong source");
  dtc_subset_a: assert property ((dtc_req_o & ~irq_o) == '0)
    else $error("transfer request without interrupt level");
  dma_source_a: assert property (
    dma_req_o == {irq_o[32], irq_o[24], irq_o[16], irq_o[8], irq_o[0]})
    else $error("dma request differs from slot a level");
  req_hold_a: assert property (|($past(irq_o) & ~irq_o) |->
    $past(wr_i, 2) || $past(|dma_bus_req_i, 2))
    else $error("request dropped without clear");
  slot_b_rise_a: assert property ($rose(irq_o[1]) |->
    $past(wr_i, 2) || $past(capture_i[1] || compare_i[1], 2))
    else $error("slot b request without cause");
  slot_e_rise_a: assert property ($rose(irq_o[4]) |->
    $past(wr_i, 2) || $past(compare_i[4], 2))
    else $error("slot e request without compare");
  reset_state_a: assert property (disable iff (1'b0) srst_i |=>
    irq_o == '0 && dma_req_o == '0 && out_pos_o == '0)
    else $error("outputs not cleared by reset");
  pwm1_pins_a: assert property (wr_i && addr_i == 8'h02 && wdata_i[3:0] == 4'h2 |->
    ##2 !out_pos_o[0] && out_neg_o[0])
    else $error("pwm mode 1 pin levels wrong");
  cover property ($fell(dma_req_o[0]));
  cover property ($rose(irq_o[38]));
  cover property ($rose(irq_o[15]));
endmodule : timer_unit_irq_properties

bind timer_unit_irq timer_unit_irq_properties #(.CNT_W(CNT_W)) u_props (.sys_clk_i, .srst_i,
  .addr_i, .wdata_i, .wr_i, .capture_i, .compare_i, .dma_bus_req_i, .irq_o, .dtc_req_o,
  .dma_req_o, .out_pos_o, .out_neg_o);

// ### tb/dma_ctrl_model.sv
// dma controller model: takes the bus some cycles after a request
module dma_ctrl_model #(
  parameter int LAT = 4
) (
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic [4:0] req_i,
  output logic [4:0] bus_req_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] wait_q;
  always_ff @(posedge clk_i) begin
    bus_req_o <= '0;
    if (srst_i || !(|req_i)) begin
      wait_q <= '0;
    end else if (wait_q == 4'(LAT)) begin
      bus_req_o <= req_i;
      wait_q <= '0;
    end else begin
      wait_q <= wait_q + 4'h1;
    end
  end
endmodule : dma_ctrl_model

// ### tb/testbench.sv
// self-checking bench for the timer unit event and request logic
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk_i = 1'b0;
  logic srst_i = 1'b1;
  logic [7:0] addr_i = '0;
  logic [15:0] wdata_i = '0;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic [35:0] capture_i = '0;
  logic [35:0] compare_i = '0;
  logic [2:1] count_down_i = '0;
  logic [4:0] dma_bus_req_i;
  logic [15:0] rdata_o;
  logic [47:0] irq_o;
  logic [47:0] dtc_req_o;
  logic [4:0] dma_req_o;
  logic [5:0] out_pos_o;
  logic [5:0] out_neg_o;
  int mismatches = 0;
  int samples_checked = 0;
  always #5 sys_clk_i = ~sys_clk_i;
  timer_unit_irq u_dut (.sys_clk_i, .srst_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o,
    .capture_i, .compare_i, .count_down_i, .dma_bus_req_i, .irq_o, .dtc_req_o, .dma_req_o,
    .out_pos_o, .out_neg_o);
  dma_ctrl_model u_dma (.clk_i(sys_clk_i), .srst_i, .req_i(dma_req_o), .bus_req_o(dma_bus_req_i));
  // ==========
  // helpers
  task automatic chk(string n, logic [47:0] got, logic [47:0] exp);
    samples_checked++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", n, exp, got);
    end
  endtask : chk
  task automatic settle(int n);
    repeat (n) @(posedge sys_clk_i);
    #1;
  endtask : settle
  task automatic wr(logic [7:0] a, logic [15:0] d);
    @(posedge sys_clk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge sys_clk_i);
    wr_i <= 1'b0;
  endtask : wr
  task automatic rd(logic [7:0] a, logic [15:0] exp, string n);
    @(posedge sys_clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge sys_clk_i);
    rd_i <= 1'b0;
    #1;
    chk(n, 48'(rdata_o), 48'(exp));
  endtask : rd
  task automatic pulse(logic [35:0] c, logic [35:0] m);
    @(posedge sys_clk_i);
    capture_i <= c;
    compare_i <= m;
    @(posedge sys_clk_i);
    capture_i <= '0;
    compare_i <= '0;
    settle(2);
  endtask : pulse
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : tally_and_finish
  // ==========
  // scenarios
  task automatic t_reset();
    chk("pins", 48'(out_pos_o), 48'h0);
    rd(8'h02, 16'h0000, "mode");
    rd(8'h82, 16'h0000, "xcap");
    rd(8'h90, 16'h0000, "unmapped");
    $display("reset test done");
  endtask : t_reset
  task automatic t_capcmp();
    pulse(36'h0, 36'h002);
    chk("masked", 48'(irq_o[7:0]), 48'h0);
    wr(8'h01, 16'h00ff);
    settle(2);
    chk("late enable", 48'(irq_o[7:0]), 48'h02);
    pulse(36'h010, 36'h0);
    chk("capture e", 48'(irq_o[7:0]), 48'h02);
    pulse(36'h0, 36'h030);
    chk("compare ef", 48'(irq_o[7:0]), 48'h32);
    wr(8'h00, 16'h0000);
    settle(2);
    chk("cleared", 48'(irq_o[7:0]), 48'h0);
    wr(8'h11, 16'h00ff);
    pulse(36'h0, 36'hfc0);
    chk("ch1 slots", 48'(irq_o[15:8]), 48'h03);
    wr(8'h10, 16'h0000);
    $display("capture compare test done");
  endtask : t_capcmp
  task automatic t_dma();
    int i;
    wr(8'h51, 16'h0001);
    pulse(36'h0, 36'h0_4000_0000);
    chk("ch5 no dma", 48'({irq_o[40], dma_req_o}), 48'h20);
    wr(8'h01, 16'h0001);
    pulse(36'h0, 36'h001);
    chk("dtc a", 48'(dtc_req_o[0]), 48'h1);
    for (i = 0; i < 20 && dma_req_o[0] !== 1'b0; i++) settle(1);
    if (i == 20) begin
      mismatches++;
      tally_and_finish();
    end
    rd(8'h00, 16'h0000, "dma cleared");
    $display("dma test done");
  endtask : t_dma
  task automatic t_count();
    wr(8'h04, 16'hfffe);
    wr(8'h44, 16'hfffe);
    wr(8'h01, 16'h0040);
    wr(8'h41, 16'h0040);
    wr(8'h80, 16'h0011);
    settle(6);
    chk("ovf", 48'({irq_o[38], irq_o[6]}), 48'h3);
    chk("ovf dtc", 48'({dtc_req_o[38], dtc_req_o[6]}), 48'h2);
    wr(8'h80, 16'h0000);
    wr(8'h04, 16'h1234);
    settle(3);
    rd(8'h04, 16'h1234, "stopped");
    chk("ovf held", 48'(irq_o[6]), 48'h1);
    wr(8'h00, 16'h0000);
    settle(2);
    chk("ovf clear", 48'(irq_o[6]), 48'h0);
    @(posedge sys_clk_i);
    count_down_i <= 2'b11;
    wr(8'h12, 16'h0004);
    wr(8'h14, 16'h0002);
    wr(8'h11, 16'h0080);
    wr(8'h80, 16'h0002);
    settle(6);
    chk("unf", 48'(irq_o[15]), 48'h1);
    wr(8'h80, 16'h0000);
    wr(8'h10, 16'h0000);
    settle(2);
    chk("unf clear", 48'(irq_o[15]), 48'h0);
    $display("count test done");
  endtask : t_count
  task automatic t_pins();
    wr(8'h33, 16'h0003);
    settle(1);
    chk("oe off", 48'(out_pos_o[3]), 48'h0);
    wr(8'h81, 16'h0008);
    wr(8'h33, 16'h0003);
    settle(1);
    chk("oe on", 48'({out_pos_o[3], out_neg_o[3]}), 48'h3);
    wr(8'h02, 16'h0002);
    settle(1);
    chk("pwm1", 48'({out_pos_o[0], out_neg_o[0]}), 48'h1);
    wr(8'h03, 16'h0001);
    settle(1);
    chk("pwm1 init", 48'({out_pos_o[0], out_neg_o[0]}), 48'h3);
    $display("pin test done");
  endtask : t_pins
  task automatic t_xcap();
    wr(8'h21, 16'h0001);
    pulse(36'h040, 36'h0);
    chk("xcap off", 48'(irq_o[16]), 48'h0);
    wr(8'h82, 16'h0001);
    pulse(36'h040, 36'h0);
    chk("xcap on", 48'(irq_o[16]), 48'h1);
    $display("capture source test done");
  endtask : t_xcap
  initial begin
    repeat (8) @(posedge sys_clk_i);
    srst_i <= 1'b0;
    settle(1);
    t_reset();
    t_capcmp();
    t_dma();
    t_count();
    t_pins();
    t_xcap();
    tally_and_finish();
  end
endmodule : testbench
